// >>> bench/qdsc_host_model.sv
// Serial bus master that commands the driver block
`timescale 1ns/1ps
module qdsc_host_model (
	output logic      select_n,
	output logic      sclk,
	output logic      si,
	input  wire logic so_out,
	input  wire logic so_oe
);
	import qdsc_pkg::*;
	localparam int HALF_NS = 80; // Link clock half period
	// Idle: deselected, clock parked low, data pulled down
	initial
	begin
		select_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	// One frame of n bits, top bit first; returns bits seen on rises
	task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0;
		#3 select_n <= 1'b0;
		#500;
		for (int i = n - 1; i >= 0; i--)
		begin
			si <= tx[i];
			#HALF_NS sclk <= 1'b1;
			rx = {rx[14:0], so_oe ? so_out : 1'bz};
			#HALF_NS sclk <= 1'b0;
		end
		#HALF_NS select_n <= 1'b1;
		si <= 1'b0;
		#XFER_GAP_NS;
	endtask
	// Clock and data wiggled while deselected; the block must not react
	task automatic stray(input int n);
		for (int i = 0; i < n; i++)
		begin
			#HALF_NS sclk <= 1'b1;
			si <= 1'b1;
			#HALF_NS sclk <= 1'b0;
			si <= 1'b0;
		end
	endtask
endmodule

// >>> bench/qdsc_top_sva.sv
// Port assertions for the quad driver serial control block
`timescale 1ns/1ps
module qdsc_top_sva
	import qdsc_pkg::*;
(
	input wire logic           hclk,
	input wire logic           hresetn,
	input wire logic           hsel,
	input wire logic [1:0]     htrans,
	input wire logic           hwrite,
	input wire logic           hreadyout,
	input wire logic           hresp,
	input wire logic           select_n,
	input wire logic           sclk,
	input wire logic           so_out,
	input wire logic           so_oe,
	input wire logic           par_in_0,
	input wire logic           par_in_1,
	input wire logic           par_in_2,
	input wire logic           par_in_3,
	input wire logic [NCH-1:0] oc_flt,
	input wire logic [NCH-1:0] ol_flt,
	input wire logic           driver_0,
	input wire logic           driver_1,
	input wire logic           driver_2,
	input wire logic           driver_3,
	input wire logic           status_out,
	input wire logic           status_oe
);
	logic [NCH-1:0] drv;     // Driver states
	logic [NCH-1:0] par;     // Parallel inputs
	logic [NCH-1:0] par_q;   // Parallel inputs last cycle
	logic [3:0]     quiet_q; // Selected cycles with nothing moving drivers
	assign drv = {driver_3, driver_2, driver_1, driver_0};
	assign par = {par_in_3, par_in_2, par_in_1, par_in_0};
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Count quiet cycles; any deselected cycle, input move or bus write restarts
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			par_q <= '0;
			quiet_q <= 4'h0;
		end
		else
		begin
			par_q <= par;
			if (select_n || par != par_q || (hsel && htrans == HTRANS_NONSEQ && hwrite))
				quiet_q <= 4'h0;
			else if (quiet_q != 4'hf)
				quiet_q <= quiet_q + 4'h1;
		end
	end
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_so_float: assert property (select_n [*8] |-> !so_oe)
		else $error("serial out driven while deselected");
	a_so_quiet: assert property (select_n [*8] |-> $stable(so_out))
		else $error("serial out shifted while deselected");
	a_so_enable: assert property ($rose(so_oe) |-> !select_n && !$past(select_n, 2))
		else $error("serial out enabled without select");
	a_so_fall: assert property (so_oe && $past(so_oe) && $changed(so_out) |-> !sclk && !$past(sclk, 2))
		else $error("serial out moved off falling clock");
	a_status_none: assert property (((ol_flt | oc_flt) == 4'h0) [*8] |-> !status_oe)
		else $error("status line active with no fault");
	a_status_hit: assert property ((|((ol_flt & ~drv) | (oc_flt & drv))) [*8] |-> status_oe)
		else $error("status line idle with fault");
	a_status_drain: assert property (status_out == 1'b0)
		else $error("status line driven high");
	a_drv_hold: assert property (quiet_q >= 4'h8 |-> $stable(drv))
		else $error("drivers moved mid frame");
	c_frame: cover property ($rose(so_oe));
	c_status: cover property ($rose(status_oe));
	c_drive: cover property ($rose(driver_0));
endmodule

// >>> bench/tb_quad_driver_serial_control.sv
// Self-checking bench for the quad driver serial control block
`timescale 1ns/1ps
module tb_quad_driver_serial_control;
	import qdsc_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        select_n, sclk, si, so_out, so_oe, status_out, status_oe;
	logic        par_in_0, par_in_1, par_in_2, par_in_3;
	logic        driver_0, driver_1, driver_2, driver_3;
	logic [3:0]  oc_flt, stb_flt, ol_flt, stg_flt;
	logic [15:0] rx;
	int          fail_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	assign hready = hreadyout;
	qdsc_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .select_n, .sclk, .si, .so_out, .so_oe, .par_in_0,
		.par_in_1, .par_in_2, .par_in_3, .oc_flt, .stb_flt, .ol_flt, .stg_flt, .driver_0,
		.driver_1, .driver_2, .driver_3, .status_out, .status_oe, .irq);
	qdsc_host_model u_host (.select_n, .sclk, .si, .so_out, .so_oe);
	always #5 hclk = ~hclk;
	// Print counts and verdict, then stop
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One single AHB-Lite transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rdat = hrdata;
	endtask
	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	// Driver pins as one word
	function automatic logic [31:0] drv();
		return {28'h0, driver_3, driver_2, driver_1, driver_0};
	endfunction
	// Cut a hang short
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			fail_count++;
			final_report();
		end
	end
	// Main sequence
	initial
	begin
		{hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{par_in_3, par_in_2, par_in_1, par_in_0} = 4'h0;
		{stg_flt, ol_flt, stb_flt, oc_flt} = 16'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, unmapped place
		rd(OFF_INT_ENABLE, {30'h0, INT_ENABLE_RST});
		rd(OFF_CTRL, {31'h0, CTRL_EN_RST});
		rd(OFF_CMD_VIEW, 32'h0);
		xfer(1'b1, 8'h40, 32'hffffffff);
		rd(8'h40, 32'h0);
		// Plain 8-bit command, upper nibble ignored
		u_host.frame(16'h00f5, 8, rx);
		chk({16'h0, rx}, 32'h0);
		chk(drv(), 32'h5);
		rd(OFF_CMD_VIEW, 32'h55);
		// Each parallel input ORs onto its own driver
		for (int i = 0; i < 4; i++)
		begin
			@(posedge hclk);
			{par_in_3, par_in_2, par_in_1, par_in_0} <= 4'h1 << i;
			repeat (10) @(posedge hclk);
			chk(drv(), 32'h5 | (32'h1 << i));
		end
		{par_in_3, par_in_2, par_in_1, par_in_0} <= 4'h0;
		// Long frame: early bits pass through, last nibble commands
		u_host.frame(16'h3cf5, 16, rx);
		chk({16'h0, rx}, 32'h3c);
		chk(drv(), 32'h5);
		u_host.stray(4);
		// Each fault kind pulsed between frames, drivers 0101
		for (int k = 0; k < 4; k++)
		begin
			@(posedge hclk);
			{stg_flt, ol_flt, stb_flt, oc_flt} <= 16'hf << (4 * k);
			repeat (40) @(posedge hclk);
			rd(OFF_FAULT_VIEW, {23'h0, !k[0], k[1] ? 8'haa : 8'h55});
			{stg_flt, ol_flt, stb_flt, oc_flt} <= 16'h0;
			repeat (10) @(posedge hclk);
			u_host.frame(16'h0005, 8, rx);
			chk({16'h0, rx}, (k < 2) ? 32'h5 : 32'ha);
		end
		// Interrupt raise, mask, clear
		rd(OFF_INT_STATUS, 32'h3);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, OFF_INT_ENABLE, 32'h1);
		rd(OFF_INT_ENABLE, 32'h1);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, OFF_INT_CLEAR, 32'h1);
		rd(OFF_INT_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, OFF_INT_ENABLE, 32'h2);
		rd(OFF_INT_ENABLE, 32'h2);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, OFF_INT_CLEAR, 32'h3);
		xfer(1'b1, OFF_INT_STATUS, 32'h3);
		rd(OFF_INT_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Driver enable off and back on
		xfer(1'b1, OFF_CTRL, 32'h0);
		repeat (10) @(posedge hclk);
		chk(drv(), 32'h0);
		rd(OFF_CMD_VIEW, 32'h05);
		xfer(1'b1, OFF_CTRL, 32'h1);
		repeat (10) @(posedge hclk);
		chk(drv(), 32'h5);
		final_report();
	end
endmodule
bind qdsc_top qdsc_top_sva u_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hreadyout, .hresp,
	.select_n, .sclk, .so_out, .so_oe, .par_in_0, .par_in_1, .par_in_2, .par_in_3, .oc_flt,
	.ol_flt, .driver_0, .driver_1, .driver_2, .driver_3, .status_out, .status_oe);

// >>> rtl/qdsc_fault.sv
// Per-channel fault qualification and accumulation between frames
`timescale 1ns/1ps
module qdsc_fault
	import qdsc_pkg::*;
(
	input  wire logic           hclk,
	input  wire logic           hresetn,
	input  wire logic [NCH-1:0] drv_on,      // Present driver state
	input  wire logic [NCH-1:0] oc_flt,      // Overcurrent sensed
	input  wire logic [NCH-1:0] stb_flt,     // Short to battery sensed
	input  wire logic [NCH-1:0] ol_flt,      // Open load sensed
	input  wire logic [NCH-1:0] stg_flt,     // Short to ground sensed
	input  wire logic           frame_end,   // Select rose: restart window
	output logic [NCH-1:0]      live_q,      // Qualified faults now
	output logic [NCH-1:0]      acc_q,       // Faults since last select rise
	output logic                status_q     // Open load or overcurrent present
);
	logic [NCH-1:0] live_d;

	// On-state faults only while on, off-state faults only while off
	always_comb
	begin
		live_d = (drv_on & (oc_flt | stb_flt))
			| (~drv_on & (ol_flt | stg_flt));
	end

	// Live register and status line source
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			live_q <= '0;
			status_q <= 1'b0;
		end
		else
		begin
			live_q <= live_d;
			status_q <= |((drv_on & oc_flt) | (~drv_on & ol_flt));
		end
	end

	// Accumulate; a fault in the restart cycle is kept
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			acc_q <= '0;
		else if (frame_end)
			acc_q <= live_d;
		else
			acc_q <= acc_q | live_d;
	end
endmodule

// >>> rtl/qdsc_pkg.sv
// Shared constants for the quad driver serial control block
package qdsc_pkg;
	localparam int NCH = 4;                          // Number of drivers
	localparam int FRAME_BITS = 8;                   // Command word length
	localparam int ADDR_W = 8;                       // Decoded address bits
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_INT_CLEAR = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CMD_VIEW = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_FAULT_VIEW = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h14;
	// Interrupt status field positions
	localparam int INT_FRAME_POS = 0;                // Select rose, command applied
	localparam int INT_FAULT_POS = 1;                // Status line went active
	localparam int INT_W = 2;                        // Interrupt field width
	// Control field positions
	localparam int CTRL_EN_POS = 0;                  // Drivers allowed on
	// Reset values
	localparam logic [INT_W-1:0] INT_ENABLE_RST = 2'h0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [NCH-1:0] CMD_RST = 4'h0;
	// Host-side timing, for reference by the far end
	localparam int CLK_MHZ = 100;
	localparam int XFER_GAP_NS = 1000;               // Select high between frames
	localparam int XFER_GAP_CYC = (XFER_GAP_NS * CLK_MHZ + 999) / 1000;
	// AHB transfer type
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> rtl/qdsc_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module qdsc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] pin,
	output logic [W-1:0]      level,
	output logic [W-1:0]      rise,
	output logic [W-1:0]      fall
);
	logic [W-1:0] s1_q;   // First stage, read only by second
	logic [W-1:0] s2_q;   // Second stage
	logic [W-1:0] s3_q;   // Third stage

	// Shift chain
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a change once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					level[g] <= RST_VAL[g];
					rise[g] <= 1'b0;
					fall[g] <= 1'b0;
				end
				else
				begin
					// Agreed and different from the held level
					if (s2_q[g] == s3_q[g] && s3_q[g] != level[g])
						level[g] <= s3_q[g];
					rise[g] <= (s2_q[g] == s3_q[g]) && s3_q[g] && !level[g];
					fall[g] <= (s2_q[g] == s3_q[g]) && !s3_q[g] && level[g];
				end
			end
		end
	endgenerate
endmodule

// >>> rtl/qdsc_top.sv
// Quad driver serial control: serial port, drivers, faults, AHB registers
// Behaviour
// - Driver on when command bit or input high; here only while the CTRL enable bit is also set
// - MSB first; low nibble commands drivers three..zero
// - Commands applied only when select rises
// - Faults shift out while command shifts in
// - On-state faults detected only while driver on
// - Off-state faults detected only while driver off
// - Status line low on open load/overcurrent
// - Serial port active only while select low
// - Serial input sampled on rising clock edges
// - Output floats unless selected; changes on falling
// - Status bits zero..three report drivers zero..three
// - Select fall loads faults since last rise
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module qdsc_top
	import qdsc_pkg::*;
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// Serial link pins
	input  wire logic                select_n,
	input  wire logic                sclk,
	input  wire logic                si,
	output logic                     so_out,
	output logic                     so_oe,
	// Parallel inputs
	input  wire logic                par_in_0,
	input  wire logic                par_in_1,
	input  wire logic                par_in_2,
	input  wire logic                par_in_3,
	// Fault sense inputs from the output stages
	input  wire logic [NCH-1:0]      oc_flt,
	input  wire logic [NCH-1:0]      stb_flt,
	input  wire logic [NCH-1:0]      ol_flt,
	input  wire logic [NCH-1:0]      stg_flt,
	// Driver gates
	output logic                     driver_0,
	output logic                     driver_1,
	output logic                     driver_2,
	output logic                     driver_3,
	// Open-drain status line
	output logic                     status_out,
	output logic                     status_oe,
	// Interrupt
	output logic                     irq
);
	localparam int NSYNC = 3 + NCH + 4 * NCH;           // Pins through the synchroniser
	localparam logic [NSYNC-1:0] SYNC_RST = {{(NSYNC-3){1'b0}}, 3'b100};

	logic [NSYNC-1:0] sync_level;                        // Filtered pin levels
	logic [NSYNC-1:0] sync_rise;                         // Rising edge pulses
	logic [NSYNC-1:0] sync_fall;                         // Falling edge pulses
	logic             sel_lvl;                           // Select, filtered
	logic             sel_rise;                          // Frame end
	logic             sel_fall;                          // Frame start
	logic             sclk_rise;                         // Serial clock rising
	logic             sclk_fall;                         // Serial clock falling
	logic             si_lvl;                            // Serial data, filtered
	logic [NCH-1:0]   par_lvl;                           // Parallel inputs, filtered
	logic [NCH-1:0]   oc_s;                              // Sensed faults, filtered
	logic [NCH-1:0]   stb_s;
	logic [NCH-1:0]   ol_s;
	logic [NCH-1:0]   stg_s;
	logic [FRAME_BITS-1:0] shift_q;                      // Serial shift register
	logic [NCH-1:0]   cmd_q;                             // Applied serial command
	logic [NCH-1:0]   drv_q;                             // Driver state
	logic [NCH-1:0]   live;                              // Qualified faults now
	logic [NCH-1:0]   acc;                               // Faults since last frame
	logic             status_act;                        // Status condition present
	logic             status_prev_q;                     // For status edge
	logic [INT_W-1:0] int_status_q;                      // Sticky events
	logic [INT_W-1:0] int_enable_q;                      // Event mask
	logic [INT_W-1:0] int_set;                           // Events this cycle
	logic [INT_W-1:0] int_clr;                           // Software clear this cycle
	logic             ctrl_en_q;                         // Drivers enabled
	logic             wr_pend_q;                         // Write data phase pending
	logic [ADDR_W-1:0] wr_addr_q;                        // Address of pending write
	logic             addr_ok;                           // Valid address phase
	logic [31:0]      rd_val;                            // Read mux

	// Link, parallel input and fault pins through three-stage filter
	qdsc_sync #(
		.W       (NSYNC),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     ({stg_flt, ol_flt, stb_flt, oc_flt,
			par_in_3, par_in_2, par_in_1, par_in_0, select_n, sclk, si}),
		.level   (sync_level),
		.rise    (sync_rise),
		.fall    (sync_fall)
	);

	assign si_lvl = sync_level[0];
	assign sclk_rise = sync_rise[1];
	assign sclk_fall = sync_fall[1];
	assign sel_lvl = sync_level[2];
	assign sel_rise = sync_rise[2];
	assign sel_fall = sync_fall[2];
	assign par_lvl = sync_level[3 +: NCH];
	assign oc_s = sync_level[3 + NCH +: NCH];
	assign stb_s = sync_level[3 + 2 * NCH +: NCH];
	assign ol_s = sync_level[3 + 3 * NCH +: NCH];
	assign stg_s = sync_level[3 + 4 * NCH +: NCH];

	// Fault qualification against driver state
	qdsc_fault u_fault (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.drv_on    (drv_q),
		.oc_flt    (oc_s),
		.stb_flt   (stb_s),
		.ol_flt    (ol_s),
		.stg_flt   (stg_s),
		.frame_end (sel_rise),
		.live_q    (live),
		.acc_q     (acc),
		.status_q  (status_act)
	);

	// Shift register: load on select fall, shift on clock rise while selected
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			shift_q <= '0;
		else if (sel_fall)
			// Upper bits zero, fault bit n in position n
			shift_q <= {{(FRAME_BITS-NCH){1'b0}}, acc};
		else if (!sel_lvl && sclk_rise)
			// Sample data, oldest bit moves toward the output
			shift_q <= {shift_q[FRAME_BITS-2:0], si_lvl};
	end

	// Serial output: MSB shown at frame start, next bit on each falling clock
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			so_out <= 1'b0;
			so_oe <= 1'b0;
		end
		else
		begin
			so_oe <= !sel_lvl && !sel_rise;
			if (sel_fall)
				so_out <= 1'b0;                               // Bit 7 of the fault byte
			else if (!sel_lvl && sclk_fall)
				so_out <= shift_q[FRAME_BITS-1];
		end
	end

	// Apply last four bits when select rises
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cmd_q <= CMD_RST;
		else if (sel_rise)
			cmd_q <= shift_q[NCH-1:0];
	end

	// Drivers: serial command OR parallel input, gated by software enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			drv_q <= '0;
		else
			drv_q <= (cmd_q | par_lvl) & {NCH{ctrl_en_q}};
	end

	assign driver_0 = drv_q[0];
	assign driver_1 = drv_q[1];
	assign driver_2 = drv_q[2];
	assign driver_3 = drv_q[3];

	// Open-drain status: drive low while open load or overcurrent is present
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status_out <= 1'b0;
			status_oe <= 1'b0;
			status_prev_q <= 1'b0;
		end
		else
		begin
			status_out <= 1'b0;
			status_oe <= status_act;
			status_prev_q <= status_act;
		end
	end

	// Interrupt events: frame applied, status line newly active
	always_comb
	begin
		int_set = '0;
		int_set[INT_FRAME_POS] = sel_rise;
		int_set[INT_FAULT_POS] = status_act && !status_prev_q;
	end

	// Address phase qualifier
	assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

	// Software clear pulses from a write data phase
	always_comb
	begin
		int_clr = '0;
		if (wr_pend_q && wr_addr_q == OFF_INT_CLEAR)
			int_clr = hwdata[INT_W-1:0];
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			int_status_q <= '0;
		else
			int_status_q <= (int_status_q & ~int_clr) | int_set;
	end

	// Level interrupt from enabled status bits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(((int_status_q & ~int_clr) | int_set) & int_enable_q);
	end

	// Capture write address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end
		else
		begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok && hwrite)
				wr_addr_q <= haddr[ADDR_W-1:0];
		end
	end

	// Writable registers, written in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			int_enable_q <= INT_ENABLE_RST;
			ctrl_en_q <= CTRL_EN_RST;
		end
		else if (wr_pend_q)
		begin
			unique case (wr_addr_q)
				OFF_INT_ENABLE: int_enable_q <= hwdata[INT_W-1:0];
				OFF_CTRL:       ctrl_en_q <= hwdata[CTRL_EN_POS];
				default:        ;                             // Unmapped, read-only, or the interrupt clear offset
			endcase
		end
	end

	// Read mux; unmapped and write-only offsets read zero
	always_comb
	begin
		rd_val = '0;
		unique case (haddr[ADDR_W-1:0])
			OFF_INT_STATUS: rd_val[INT_W-1:0] = int_status_q;
			OFF_INT_ENABLE: rd_val[INT_W-1:0] = int_enable_q;
			OFF_CMD_VIEW:   rd_val[2*NCH-1:0] = {drv_q, cmd_q};
			OFF_FAULT_VIEW: rd_val[2*NCH:0] = {status_act, acc, live};
			OFF_CTRL:       rd_val[CTRL_EN_POS] = ctrl_en_q;
			default:        rd_val = '0;
		endcase
	end

	// Bus answer: no wait states, always OKAY, read data registered
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= '0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite)
				hrdata <= rd_val;
		end
	end
endmodule
